// *** phy_strap_option_latch.sv ***
// strap option latch: captured straps, control and advertisement images
// assumes an AXI4-Lite master on clk_i and board strap pulls during reset
`timescale 1ns/10ps
`default_nettype none
`include "strap_map.svh"

module phy_strap_option_latch
    import strap_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // strap pins, shared with core outputs after reset
    input  wire strap_pins_s strap_in_i,
    input  wire strap_pins_s core_out_i,
    output var  strap_pins_s strap_out_o,
    output var  strap_pins_s strap_oe_o,
    input  wire logic        fiber_enable_i,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // decoded configuration
    output var  logic [4:0]  mgmt_addr_o,
    output var  if_mode_e    if_mode_o,
    output var  logic        if_mode_rsvd_o,
    output var  logic        isolate_o,
    output var  logic        speed_100_o,
    output var  logic        fiber_mode_o,
    output var  logic        fef_enable_o
);

    // offsets need eight address bits
    generate
        if (ADDR_W < 8)
        begin : g_chk
            $error("ADDR_W must be at least 8");
        end
    endgenerate

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;

    strap_cfg_s  cfg;
    logic        seed_pend;
    logic        pins_live;
    logic [15:0] ctrl_img;
    logic [15:0] adv_img;
    wr_state_e   wr_state;
    rd_state_e   rd_state;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic [31:0] stat_word;
    logic [15:0] next_ctrl;
    logic [15:0] next_adv;
    logic        fef_dis;

    // captures straps during reset, holds afterwards
    strap_sampler u_sampler (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .strap_in_i     (strap_in_i),
        .fiber_enable_i (fiber_enable_i),
        .cfg_o          (cfg)
    );

    assign fef_dis = cfg.fiber & ~cfg.speed_raw;

    // seed images on the first enabled cycle after release
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            seed_pend <= 1'b1;
        else if (ce_i)
            seed_pend <= 1'b0;
    end

    // drive pins only after capture
    // pins stay inputs until images are seeded, so straps are never fought
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            pins_live <= 1'b0;
        else if (ce_i && seed_pend)
            pins_live <= 1'b1;
    end

    // pin output flops, one per strap bit
    genvar gi;
    generate
        for (gi = 0; gi < $bits(strap_pins_s); gi++)
        begin : g_pin
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    strap_out_o[gi] <= 1'b0;
                    strap_oe_o[gi]  <= 1'b0;
                end
                else if (ce_i)
                begin
                    strap_out_o[gi] <= core_out_i[gi];
                    strap_oe_o[gi]  <= pins_live;
                end
            end
        end
    endgenerate

    // write happens once address and data are both held
    assign wr_fire = (wr_state == WR_IDLE) && aw_held && w_held;

    // byte-lane merge of software writes into the images
    always_comb
    begin
        next_ctrl = ctrl_img;
        next_adv  = adv_img;
        if (aw_addr == `CTRL_OFS)
        begin
            if (w_strb[0])
                next_ctrl[7:0] = w_data[7:0];
            if (w_strb[1])
                next_ctrl[15:8] = w_data[15:8];
        end
        if (aw_addr == `ADV_OFS)
        begin
            if (w_strb[0])
                next_adv[7:0] = w_data[7:0];
            if (w_strb[1])
                next_adv[15:8] = w_data[15:8];
            next_adv[4:0] = `ADV_SEL_RST; // selector is fixed
        end
    end

    // control image, seeded from straps
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ctrl_img <= `CTRL_RST;
        else if (ce_i)
        begin
            if (seed_pend)
            begin
                ctrl_img <= `CTRL_RST;
                // high is 100, low is 10
                // fiber runs only at 100
                ctrl_img[`CTRL_SPEED_BIT] <= cfg.speed_raw | cfg.fiber;
                ctrl_img[`CTRL_ISO_BIT]   <= cfg.isolate;
            end
            else if (wr_fire)
                ctrl_img <= next_ctrl;
        end
    end

    // advertisement image, seeded from straps
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            adv_img <= `ADV_RST;
        else if (ce_i)
        begin
            if (seed_pend)
            begin
                adv_img <= `ADV_RST;
                adv_img[`ADV_100FD_BIT] <= cfg.speed_raw | cfg.fiber;
                adv_img[`ADV_100HD_BIT] <= cfg.speed_raw | cfg.fiber;
                adv_img[`ADV_10FD_BIT]  <= ~cfg.fiber;
                adv_img[`ADV_10HD_BIT]  <= ~cfg.fiber;
            end
            else if (wr_fire)
                adv_img <= next_adv;
        end
    end

    // decoded outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mgmt_addr_o    <= `ADDR_RST;
            if_mode_o      <= MODE_MII;
            if_mode_rsvd_o <= 1'b0;
            isolate_o      <= 1'b0;
            speed_100_o    <= 1'b1;
            fiber_mode_o   <= 1'b0;
            fef_enable_o   <= 1'b0;
        end
        else if (ce_i && !seed_pend)
        begin
            mgmt_addr_o    <= cfg.mgmt_addr;
            if_mode_o      <= cfg.mode;
            if_mode_rsvd_o <= mode_reserved(cfg.mode);
            isolate_o      <= ctrl_img[`CTRL_ISO_BIT];
            speed_100_o    <= ctrl_img[`CTRL_SPEED_BIT];
            fiber_mode_o   <= cfg.fiber;
            fef_enable_o   <= cfg.fiber & ~fef_dis;
        end
    end

    // read-only view of what was captured
    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[`STAT_ADDR_LSB +: 5] = cfg.mgmt_addr;
        stat_word[`STAT_MODE_LSB +: 3] = cfg.mode;
        stat_word[`STAT_ISO_BIT]       = cfg.isolate;
        stat_word[`STAT_SPEED_BIT]     = cfg.speed_raw & ~cfg.fiber;
        stat_word[`STAT_FIBER_BIT]     = cfg.fiber;
        stat_word[`STAT_FEFD_BIT]      = fef_dis;
        stat_word[`STAT_RSVD_BIT]      = mode_reserved(cfg.mode);
        stat_word[`STAT_DONE_BIT]      = ~seed_pend;
    end

    // write address and data taken in either order
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr       <= 8'h00;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr[7:0];
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            else if (!aw_held && wr_state == WR_IDLE)
                s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
        end
        else if (ce_i)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held <= 1'b0;
            else if (!w_held && wr_state == WR_IDLE)
                s_axi_wready <= 1'b1;
        end
    end

    // write response; status word is read-only, unmapped gives slverr
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_state     <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end
        else if (ce_i)
        begin
            unique case (wr_state)
                WR_IDLE:
                    if (wr_fire)
                    begin
                        wr_state     <= WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (aw_addr == `CTRL_OFS || aw_addr == `ADV_OFS)
                                        ? `RESP_OKAY : `RESP_SLVERR;
                    end
                WR_RESP:
                    if (s_axi_bready)
                    begin
                        wr_state     <= WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
            endcase
        end
    end

    // read channel, one outstanding read
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_state      <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (ce_i)
        begin
            unique case (rd_state)
                RD_IDLE:
                    if (s_axi_arvalid && s_axi_arready)
                    begin
                        rd_state      <= RD_RESP;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rresp   <= `RESP_OKAY;
                        case (s_axi_araddr[7:0])
                            `CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_img};
                            `ADV_OFS:  s_axi_rdata <= {16'h0000, adv_img};
                            `STAT_OFS: s_axi_rdata <= stat_word;
                            default:
                            begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= `RESP_SLVERR;
                            end
                        endcase
                    end
                    else
                        s_axi_arready <= 1'b1;
                RD_RESP:
                    if (s_axi_rready)
                    begin
                        rd_state     <= RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
            endcase
        end
    end

endmodule : phy_strap_option_latch

`default_nettype wire

// *** strap_board.sv ***
// board side of the shared strap pins: fitted resistors or internal pulls
// assumes the device output enable takes the pins over after reset
`timescale 1ns/10ps
`default_nettype none

module strap_board
    import strap_pkg::*;
(
    // fitted resistors and their levels
    input  wire logic [7:0]  fit_i,
    input  wire strap_pins_s board_i,
    // device side of the pins
    input  wire strap_pins_s drive_i,
    input  wire strap_pins_s oe_i,
    // resulting pin levels
    output var  strap_pins_s pin_o
);
    // internal pulls: address 001, mode 000, isolate low, speed high
    localparam logic [7:0] PULLS = 8'h21;
    logic [7:0]            rest;

    assign rest = (fit_i & board_i) | (~fit_i & PULLS);
    assign pin_o = (oe_i & drive_i) | (~oe_i & rest);
endmodule : strap_board

`default_nettype wire

// *** strap_latch_asserts.sv ***
// checker of the strap option latch, bound to its top module
// assumes straps stand at the last reset edge
`timescale 1ns/10ps
`default_nettype none

module strap_latch_asserts
    import strap_pkg::*;
(
    // clock, reset, pins
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire strap_pins_s strap_in_i,
    input  wire logic        fiber_enable_i,
    input  wire strap_pins_s strap_oe_o,
    // decoded configuration
    input  wire logic [4:0]  mgmt_addr_o,
    input  wire if_mode_e    if_mode_o,
    input  wire logic        if_mode_rsvd_o,
    input  wire logic        isolate_o,
    input  wire logic        speed_100_o,
    input  wire logic        fiber_mode_o,
    input  wire logic        fef_enable_o
);
    default clocking cb @(posedge clk_i); endclocking

    // release then two enabled edges; capture edge is three back
    sequence rel;
        !rst_n_i ##1 (rst_n_i && ce_i) ##1 (rst_n_i && ce_i);
    endsequence

    a_addr_capture: assert property
        (rel |=> mgmt_addr_o == {2'h0, $past(strap_in_i.mgmt_addr, 3)})
        else $error("address not captured");
    a_addr_high: assert property
        (mgmt_addr_o[4:3] == 2'h0) else $error("address upper bits set");
    a_mode_capture: assert property
        (rel |=> if_mode_o == $past(strap_in_i.cfg, 3)) else $error("mode not captured");
    a_rsvd_flag: assert property
        (rel |=> if_mode_rsvd_o == (&$past(strap_in_i.cfg[1:0], 3)))
        else $error("reserved flag wrong");
    a_iso_capture: assert property
        (rel |=> isolate_o == $past(strap_in_i.isolate, 3)) else $error("isolate wrong");
    a_speed_capture: assert property
        (rel |=> speed_100_o == ($past(fiber_enable_i, 3) | $past(strap_in_i.speed_fef, 3)))
        else $error("speed wrong");
    a_fef_capture: assert property
        (rel |=> fef_enable_o == ($past(fiber_enable_i, 3) & $past(strap_in_i.speed_fef, 3)))
        else $error("far-end fault wrong");
    a_fiber_capture: assert property
        (rel |=> fiber_mode_o == $past(fiber_enable_i, 3)) else $error("fiber wrong");
    a_oe_reset: assert property
        (!rst_n_i |=> strap_oe_o == 8'h00) else $error("pins driven in reset");
    a_oe_live: assert property
        (rel |=> strap_oe_o == 8'hFF) else $error("pins not live");
    a_hold_stable: assert property
        (disable iff (!rst_n_i) $past(rst_n_i) && $past(strap_oe_o) == 8'hFF
         |-> $stable(mgmt_addr_o) && $stable(if_mode_o) && $stable(fef_enable_o))
        else $error("captured value moved");

    // main scenarios
    c_fiber: cover property (rel ##1 fiber_mode_o);
    c_rsvd: cover property (rel ##1 if_mode_rsvd_o);
    c_slow: cover property (rel ##1 !speed_100_o);
endmodule : strap_latch_asserts

bind phy_strap_option_latch strap_latch_asserts u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .strap_in_i(strap_in_i),
    .fiber_enable_i(fiber_enable_i), .strap_oe_o(strap_oe_o), .mgmt_addr_o(mgmt_addr_o),
    .if_mode_o(if_mode_o), .if_mode_rsvd_o(if_mode_rsvd_o), .isolate_o(isolate_o),
    .speed_100_o(speed_100_o), .fiber_mode_o(fiber_mode_o), .fef_enable_o(fef_enable_o)
);

`default_nettype wire

// *** strap_map.svh ***
// register offsets, field positions, reset values of the strap option latch
// assumes inclusion by bare name from the package and the main module
// Overview of operation
// - management address taken from three address straps at reset, values 0 to 7
// - address straps at their pull defaults give address 00001
// - management address bits [4:3] always read as zero
// - three-bit interface mode strap latched at reset; 011 and 111 reserved
// - isolate strap low disables isolate, high selects isolate mode
// - copper mode speed strap high selects 100Mbps, low selects 10Mbps
// - captured speed strap loads speed select, control register bit 13
// - captured speed strap also sets advertised speed capability, register 4h
// - in fiber mode the speed strap is the far-end fault enable strap
// - fiber mode far-end fault strap high enables signalling, low disables it
// - fiber enable low selects copper mode, high selects fiber mode
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// byte offsets of the register words
`define CTRL_OFS        8'h00
`define ADV_OFS         8'h04
`define STAT_OFS        8'h08

// control image fields
`define CTRL_SPEED_BIT  13
`define CTRL_ISO_BIT    10
`define CTRL_RST        16'h2000

// advertisement image fields
`define ADV_100FD_BIT   8
`define ADV_100HD_BIT   7
`define ADV_10FD_BIT    6
`define ADV_10HD_BIT    5
`define ADV_SEL_RST     5'h01
`define ADV_RST         16'h01E1

// status word fields
`define STAT_ADDR_LSB   0
`define STAT_MODE_LSB   5
`define STAT_ISO_BIT    8
`define STAT_SPEED_BIT  9
`define STAT_FIBER_BIT  10
`define STAT_FEFD_BIT   11
`define STAT_RSVD_BIT   12
`define STAT_DONE_BIT   13

// captured address default and forced upper bits
`define ADDR_RST        5'h01
`define ADDR_HI_ZERO    2'h0

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// *** strap_pkg.sv ***
// types shared by the strap option latch and its sampler
// assumes strap_map.svh lies in the include path
`default_nettype none
`include "strap_map.svh"

package strap_pkg;

    // interface mode codes as strapped
    typedef enum logic [2:0] {
        MODE_MII      = 3'h0,
        MODE_RMII     = 3'h1,
        MODE_SMII     = 3'h2,
        MODE_RSVD3    = 3'h3,
        MODE_PCS_LB   = 3'h4,
        MODE_RMII_B2B = 3'h5,
        MODE_MII_B2B  = 3'h6,
        MODE_RSVD7    = 3'h7
    } if_mode_e;

    // shared strap pins, one field per pin group
    typedef struct packed {
        logic [2:0] mgmt_addr;
        logic [2:0] cfg;
        logic       isolate;
        logic       speed_fef;
    } strap_pins_s;

    // values captured at reset
    typedef struct packed {
        logic [4:0] mgmt_addr;
        if_mode_e   mode;
        logic       isolate;
        logic       speed_raw;
        logic       fiber;
    } strap_cfg_s;

    // reserved interface codes
    function automatic logic mode_reserved(input if_mode_e m);
        mode_reserved = (m == MODE_RSVD3) || (m == MODE_RSVD7);
    endfunction : mode_reserved

endpackage : strap_pkg

`default_nettype wire

// *** strap_sampler.sv ***
// samples the strap pins while reset is held and keeps them afterwards
// assumes pins carry board pull levels during reset, synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
`include "strap_map.svh"

module strap_sampler
    import strap_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // strap pins
    input  wire strap_pins_s strap_in_i,
    input  wire logic        fiber_enable_i,
    // captured values
    output var  strap_cfg_s  cfg_o
);

    // sample during reset
    // every reset cycle overwrites, so the last level before release wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cfg_o.mgmt_addr <= {`ADDR_HI_ZERO, strap_in_i.mgmt_addr};
            cfg_o.mode      <= if_mode_e'(strap_in_i.cfg);
            cfg_o.isolate   <= strap_in_i.isolate;
            cfg_o.speed_raw <= strap_in_i.speed_fef;
            cfg_o.fiber     <= fiber_enable_i;
        end
    end

endmodule : strap_sampler

`default_nettype wire

// *** tb.sv ***
// bench of the strap option latch: strap sweeps over resets, bus reads
// assumes the board model on the shared pins and a 50 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "strap_map.svh"

module tb;
    import strap_pkg::*;

    // clock, reset, pins
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        fiber_enable_i = 1'b0;
    logic [7:0]  fit = 8'h00;
    strap_pins_s board = 8'h00;
    strap_pins_s core_out = 8'h00;
    strap_pins_s strap_in;
    strap_pins_s strap_out;
    strap_pins_s strap_oe;
    // bus
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    // decoded outputs
    logic [4:0]  addr_o;
    if_mode_e    mode_o;
    logic        rsvd_o, iso_o, spd_o, fib_o, fef_o;
    int          error_cnt = 0;
    int          cmp_count = 0;

    phy_strap_option_latch dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .strap_in_i(strap_in),
        .core_out_i(core_out), .strap_out_o(strap_out), .strap_oe_o(strap_oe),
        .fiber_enable_i(fiber_enable_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mgmt_addr_o(addr_o), .if_mode_o(mode_o), .if_mode_rsvd_o(rsvd_o),
        .isolate_o(iso_o), .speed_100_o(spd_o), .fiber_mode_o(fib_o), .fef_enable_o(fef_o)
    );
    strap_board u_board (
        .fit_i(fit), .board_i(board), .drive_i(strap_out), .oe_i(strap_oe), .pin_o(strap_in)
    );

    // 20 ns period
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic summarize;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk

    // a wait that runs out ends the run
    task automatic tmo(input int n);
        if (n > 200)
        begin
            $display("[FAIL] bus answer expected 1 seen 0");
            error_cnt++;
            summarize();
        end
    endtask : tmo

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // address and data released each on its own ready
        while (!(aw && w))
        begin
            @(posedge clk_i);
            n++;
            tmo(n);
            if (!aw && awready === 1'b1)
            begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1)
            begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
            tmo(n);
        end
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (arready !== 1'b1 || n == 0)
        begin
            @(posedge clk_i);
            n++;
            tmo(n);
        end
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
            tmo(n);
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // outputs and register images against the strapped levels
    task automatic chk_cfg(input logic [2:0] a, input logic [2:0] md, input logic iso,
                           input logic spd, input logic fib);
        logic        s100;
        logic [31:0] d;
        logic [1:0]  r;
        s100 = fib | spd;
        chk("mgmt_addr", {29'h0, a}, {27'h0, addr_o});
        chk("if_mode", {29'h0, md}, {29'h0, mode_o});
        chk("mode_rsvd", {31'h0, &md[1:0]}, {31'h0, rsvd_o});
        chk("isolate", {31'h0, iso}, {31'h0, iso_o});
        chk("speed_100", {31'h0, s100}, {31'h0, spd_o});
        chk("fef_enable", {31'h0, fib & spd}, {31'h0, fef_o});
        chk("fiber", {31'h0, fib}, {31'h0, fib_o});
        chk("pins_oe", 32'hFF, {24'h0, strap_oe});
        chk("pins_out", {24'h0, core_out}, {24'h0, strap_out});
        axi_rd(8'h00, d, r);
        chk("ctrl", {18'h0, s100, 2'h0, iso, 10'h0}, d);
        axi_rd(8'h04, d, r);
        chk("adv", fib ? 32'h0181 : (spd ? 32'h01E1 : 32'h0061), d);
        axi_rd(8'h08, d, r);
        chk("stat", {18'h0, 1'b1, &md[1:0], fib & ~spd, fib, spd & ~fib, iso, md, 2'h0, a},
            d);
    endtask : chk_cfg

    initial
    begin
        int          m;
        logic [31:0] d;
        logic [1:0]  r;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk_cfg(3'h1, 3'h0, 1'b0, 1'b1, 1'b0);
        // writable control image, refused and unmapped places
        axi_wr(8'h00, 32'h0, r);
        chk("ctrl_wr_resp", `RESP_OKAY, {30'h0, r});
        @(posedge clk_i);
        chk("speed_after_wr", 32'h0, {31'h0, spd_o});
        axi_wr(8'h08, 32'hFFFF, r);
        chk("stat_wr_resp", `RESP_SLVERR, {30'h0, r});
        axi_rd(8'h10, d, r);
        chk("unmapped_resp", `RESP_SLVERR, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        // eight strap combinations, reseeding over a fresh reset each time
        for (m = 0; m < 8; m++)
        begin
            @(posedge clk_i);
            fit <= 8'hFF;
            board <= {m[2:0], m[2:0], m[0], m[1]};
            fiber_enable_i <= m[2];
            core_out <= 8'hA5 ^ m[7:0];
            rst_n_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            rst_n_i <= 1'b1;
            // one sweep keeps the enable low over release: nothing may move
            ce_i <= (m != 5);
            repeat (4) @(posedge clk_i);
            if (m == 5)
            begin
                chk("frozen_oe", 32'h0, {24'h0, strap_oe});
                chk("frozen_addr", {27'h0, `ADDR_RST}, {27'h0, addr_o});
            end
            ce_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            chk_cfg(m[2:0], m[2:0], m[0], m[1], m[2]);
        end
        summarize();
    end
endmodule : tb

`default_nettype wire
